// file: src/cpurg_defines.vh
// Constants for the CPU register set and memory map block
// Functional notes
// [RQ1] 8-bit ALU operation completes in one cycle
// [RQ2] Counter is 15 bits: upper 7, lower 8
// [RQ3] Primary pointer 8 bits, optional post inc/dec
// [RQ4] Alternate pointer 8 bits, optional post inc/dec
// [RQ5] Segment register extends 00-7F into 256 segments
// [RQ6] Reset loads stack pointer with 06F
// [RQ7] Stack pointer points free slot, push decrements
// [RQ8] Registers except accumulator, counter are memory mapped
// [RQ9] Program memory 32768 bytes, own address bus
// [RQ10] Every interrupt vectors to 00FF
// [RQ11] Erased program byte reads 00
// [RQ12] Fetching starts at address 0 after reset
// [RQ13] Return with stack pointer 6F goes to 7FFF
// [RQ14] Fetch at 7FFF returns 00, the trap opcode
// [RQ15] Program memory handled in 128-byte pages
// [RQ16] Data memory holds 1024 bytes of RAM
// [RQ17] Bytes 0F0-0FF act as registers, immediate load
// [RQ18] Register bytes support decrement and skip zero
// [RQ19] Alternate, stack, primary, segment at 0FC-0FF
// [RQ20] Direct or pointer-indirect data addressing
// [RQ21] Program data may be moved into RAM
// [RQ22] Top address bit set means no extension
// [RQ23] Stack accesses always use segment zero
// [RQ24] Pointer inc/dec wraps, no carry to segment
`ifndef CPURG_DEFINES_VH
`define CPURG_DEFINES_VH
`define CPURG_PC_W 15
`define CPURG_PU_W 7
`define CPURG_PL_W 8
`define CPURG_SP_RESET 8'h6f
`define CPURG_PC_RESET 15'h0000
`define CPURG_VECTOR 15'h00ff
`define CPURG_TRAP_ADDR 15'h7fff
`define CPURG_ERASED 8'h00
`define CPURG_TRAP_OP 8'h00
`define CPURG_PAGE_W 7
`define CPURG_ADDR_ALT 8'hfc
`define CPURG_ADDR_SP 8'hfd
`define CPURG_ADDR_PRI 8'hfe
`define CPURG_ADDR_SEG 8'hff
`define CPURG_REGS_BASE 4'hf
`define CPURG_RAM_W 10
// ALU operation codes
`define CPURG_ALU_ADD 3'h0
`define CPURG_ALU_SUB 3'h1
`define CPURG_ALU_AND 3'h2
`define CPURG_ALU_OR 3'h3
`define CPURG_ALU_XOR 3'h4
`define CPURG_ALU_SHL 3'h5
`define CPURG_ALU_SHR 3'h6
`define CPURG_ALU_PASS 3'h7
// Pointer step codes
`define CPURG_STEP_NONE 2'h0
`define CPURG_STEP_INC 2'h1
`define CPURG_STEP_DEC 2'h2
// Address source codes
`define CPURG_SRC_DIRECT 2'h0
`define CPURG_SRC_PRI 2'h1
`define CPURG_SRC_ALT 2'h2
`define CPURG_SRC_SP 2'h3
`endif

// file: src/cpurg_alu.v
// Single-cycle 8-bit arithmetic and logic unit
`timescale 1ns/100ps
`include "cpurg_defines.vh"
module cpurg_alu #(
   parameter W = 8
) (
   input wire [2:0] op_in,
   input wire [W-1:0] a_in,
   input wire [W-1:0] b_in,
   input wire carry_in,
   output reg [W-1:0] res_out,
   output reg carry_out
);
   reg [W:0] sum;
   // Purely combinational so every operation ends in the same cycle
   always @* begin
      sum = {(W+1){1'b0}};
      res_out = a_in;
      carry_out = carry_in;
      case (op_in) // RQ1
         `CPURG_ALU_ADD: begin
            sum = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, carry_in};
            res_out = sum[W-1:0];
            carry_out = sum[W];
         end
         `CPURG_ALU_SUB: begin
            sum = {1'b0, a_in} + {1'b0, ~b_in} + {{W{1'b0}}, carry_in};
            res_out = sum[W-1:0];
            carry_out = sum[W];
         end
         `CPURG_ALU_AND: res_out = a_in & b_in;
         `CPURG_ALU_OR: res_out = a_in | b_in;
         `CPURG_ALU_XOR: res_out = a_in ^ b_in;
         `CPURG_ALU_SHL: begin
            res_out = {a_in[W-2:0], carry_in};
            carry_out = a_in[W-1];
         end
         `CPURG_ALU_SHR: begin
            res_out = {carry_in, a_in[W-1:1]};
            carry_out = a_in[0];
         end
         default: res_out = b_in;
      endcase
   end
endmodule

// file: src/cpurg_core.v
// CPU register set, program fetch and data memory map
`timescale 1ns/100ps
`include "cpurg_defines.vh"
module cpurg_core #(
   parameter RAM_BYTES = 1024,
   parameter PROG_BYTES = 32768,
   parameter SEGS_USED = 8
) (
   input wire clk_in,
   input wire resetn_in,
   input wire ce_in,
   // Instruction side controls
   input wire [2:0] alu_op_in,
   input wire alu_wr_in,
   input wire [7:0] imm_in,
   input wire alu_imm_in,
   input wire [1:0] src_in,
   input wire [7:0] dir_addr_in,
   input wire mem_rd_in,
   input wire mem_wr_in,
   input wire mem_wr_acc_in,
   input wire [1:0] pri_step_in,
   input wire [1:0] alt_step_in,
   input wire push_in,
   input wire pop_in,
   input wire jump_in,
   input wire [14:0] jump_addr_in,
   input wire irq_in,
   input wire ret_in,
   input wire [14:0] ret_addr_in,
   input wire decrement_skip_zero_in,
   input wire [3:0] decrement_skip_zero_reg_in,
   input wire step_in,
   input wire prog_rd_in,
   input wire [14:0] prog_rd_addr_in,
   input wire prog_to_ram_in,
   input wire [7:0] prog_data_in,
   input wire prog_erased_in,
   // Outputs
   output wire [14:0] prog_addr_out,
   output wire [7:0] prog_page_out,
   output reg [7:0] fetch_op_out,
   output reg [14:0] instruction_counter_out,
   output reg [7:0] acc_out,
   output reg carry_out,
   output reg [7:0] rd_data_out,
   output reg [15:0] data_addr_out,
   output reg skip_out,
   output reg trap_out,
   output reg [7:0] stack_pointer_out,
   output reg [7:0] primary_ram_pointer_out,
   output reg [7:0] alt_ram_pointer_out,
   output reg [7:0] data_page_extend_out
);
   // Registers
   reg [6:0] counter_upper_half_q;
   reg [7:0] counter_lower_half_q;
   reg [7:0] acc_q;
   reg carry_q;
   reg [7:0] pri_q;
   reg [7:0] alt_q;
   reg [7:0] sp_q;
   reg [7:0] seg_q;
   reg [7:0] ram_q [0:RAM_BYTES-1];
   reg trap_pend_q;
   wire [14:0] pc = {counter_upper_half_q, counter_lower_half_q}; // RQ2
   // Reset start address, split into the two counter halves
   wire [14:0] pc_rst = `CPURG_PC_RESET;

   // Pointer stepping: wraps within 8 bits, segment untouched
   function [7:0] ptr_step;
      input [7:0] v;
      input [1:0] st;
      begin
         case (st)
            `CPURG_STEP_INC: ptr_step = v + 8'h01; // RQ24
            `CPURG_STEP_DEC: ptr_step = v - 8'h01; // RQ24
            default: ptr_step = v;
         endcase
      end
   endfunction

   // Map 16-bit data address onto RAM index; returns all-ones if none
   function [10:0] ram_index;
      input [15:0] a;
      begin
         if (a[15:8] == 8'h00 && a[7:4] == `CPURG_REGS_BASE)
            ram_index = {7'h3f, a[3:0]}; // RQ17
         else if (a[7] == 1'b0 && a[15:8] < SEGS_USED &&
               (a[15:8] != 8'h00 || a[6:0] < 7'h70))
            ram_index = {a[10:8], a[6:0]} - {3'h0, 8'h10} *
               {10'h0, a[15:8] != 8'h00}; // RQ16
         else
            ram_index = 11'h7ff;
      end
   endfunction

   // Data address formation
   reg [7:0] low_addr;
   reg [15:0] full_addr;
   always @* begin
      case (src_in) // RQ20
         `CPURG_SRC_PRI: low_addr = pri_q;
         `CPURG_SRC_ALT: low_addr = alt_q;
         `CPURG_SRC_SP: low_addr = sp_q;
         default: low_addr = dir_addr_in;
      endcase
      if (src_in == `CPURG_SRC_SP || push_in || pop_in)
         full_addr = {8'h00, push_in ? sp_q : (pop_in ? sp_q + 8'h01 :
            low_addr)}; // RQ23
      else if (low_addr[7])
         full_addr = {8'h00, low_addr}; // RQ22
      else
         full_addr = {seg_q, low_addr}; // RQ5
   end

   // Memory-mapped read of pointers and RAM
   wire [10:0] ridx = ram_index(full_addr);
   reg [7:0] rd_val;
   always @* begin
      if (full_addr == {8'h00, `CPURG_ADDR_ALT})
         rd_val = alt_q; // RQ19
      else if (full_addr == {8'h00, `CPURG_ADDR_SP})
         rd_val = sp_q; // RQ19
      else if (full_addr == {8'h00, `CPURG_ADDR_PRI})
         rd_val = pri_q; // RQ19
      else if (full_addr == {8'h00, `CPURG_ADDR_SEG})
         rd_val = seg_q; // RQ8
      else if (ridx < RAM_BYTES)
         rd_val = ram_q[ridx[9:0]];
      else
         rd_val = 8'h00;
   end

   // ALU instance
   wire [7:0] alu_res;
   wire alu_c;
   cpurg_alu #(.W(8)) u_alu (
      .op_in(alu_op_in),
      .a_in(acc_q),
      .b_in(alu_imm_in ? imm_in : rd_val),
      .carry_in(carry_q),
      .res_out(alu_res),
      .carry_out(alu_c)
   );

   // Write data and decrement-skip
   wire [7:0] wr_val = mem_wr_acc_in ? acc_q : imm_in;
   wire [7:0] decrement_skip_zero_old = ram_q[RAM_BYTES-16+decrement_skip_zero_reg_in];
   wire [7:0] decrement_skip_zero_new = decrement_skip_zero_old - 8'h01; // RQ18
   wire wr_ptr = mem_wr_in && full_addr[15:8] == 8'h00;
   wire [7:0] prog_byte = prog_erased_in ? `CPURG_ERASED : prog_data_in;

   // Program fetch address and page
   assign prog_addr_out = prog_rd_in ? prog_rd_addr_in : pc; // RQ9
   assign prog_page_out = prog_addr_out[14:`CPURG_PAGE_W]; // RQ15

   // Counter next value
   reg [14:0] pc_d;
   always @* begin
      pc_d = pc;
      if (irq_in)
         pc_d = `CPURG_VECTOR; // RQ10
      else if (ret_in && sp_q == `CPURG_SP_RESET)
         pc_d = `CPURG_TRAP_ADDR; // RQ13
      else if (ret_in)
         pc_d = ret_addr_in;
      else if (jump_in)
         pc_d = jump_addr_in;
      else if (step_in)
         pc_d = pc + (decrement_skip_zero_in && decrement_skip_zero_new == 8'h00 ? 15'h0002 :
            15'h0001); // RQ18
   end

   // Pointer next values; a memory-mapped write beats a step
   reg [7:0] pri_d;
   reg [7:0] alt_d;
   reg [7:0] sp_d;
   reg [7:0] seg_d;
   always @* begin
      pri_d = ptr_step(pri_q, pri_step_in); // RQ3
      alt_d = ptr_step(alt_q, alt_step_in); // RQ4
      seg_d = seg_q;
      if (push_in)
         sp_d = sp_q - 8'h01; // RQ7
      else if (pop_in)
         sp_d = sp_q + 8'h01;
      else
         sp_d = sp_q;
      if (wr_ptr && full_addr[7:0] == `CPURG_ADDR_ALT)
         alt_d = wr_val; // RQ8
      if (wr_ptr && full_addr[7:0] == `CPURG_ADDR_SP)
         sp_d = wr_val; // RQ8
      if (wr_ptr && full_addr[7:0] == `CPURG_ADDR_PRI)
         pri_d = wr_val; // RQ8
      if (wr_ptr && full_addr[7:0] == `CPURG_ADDR_SEG)
         seg_d = wr_val; // RQ8
   end

   // Sequential state
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         counter_upper_half_q <= pc_rst[14:8]; // RQ12
         counter_lower_half_q <= pc_rst[7:0]; // RQ12
         acc_q <= 8'h00;
         carry_q <= 1'b0;
         pri_q <= 8'h00;
         alt_q <= 8'h00;
         sp_q <= `CPURG_SP_RESET; // RQ6
         seg_q <= 8'h00;
         trap_pend_q <= 1'b0;
      end else if (ce_in) begin
         counter_upper_half_q <= pc_d[14:8];
         counter_lower_half_q <= pc_d[7:0];
         trap_pend_q <= 1'b0;
         if (alu_wr_in) begin
            acc_q <= alu_res; // RQ1
            carry_q <= alu_c;
         end
         pri_q <= pri_d;
         alt_q <= alt_d;
         sp_q <= sp_d;
         seg_q <= seg_d;
      end
   end

   // RAM array writes
   always @(posedge clk_in) begin
      if (ce_in) begin
         if (mem_wr_in && ridx < RAM_BYTES)
            ram_q[ridx[9:0]] <= prog_to_ram_in ? prog_byte : wr_val; // RQ21
         if (decrement_skip_zero_in)
            ram_q[RAM_BYTES-16+decrement_skip_zero_reg_in] <= decrement_skip_zero_new; // RQ18
      end
   end

   // Registered outputs
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         fetch_op_out <= 8'h00;
         instruction_counter_out <= 15'h0000;
         acc_out <= 8'h00;
         carry_out <= 1'b0;
         rd_data_out <= 8'h00;
         data_addr_out <= 16'h0000;
         skip_out <= 1'b0;
         trap_out <= 1'b0;
         stack_pointer_out <= `CPURG_SP_RESET;
         primary_ram_pointer_out <= 8'h00;
         alt_ram_pointer_out <= 8'h00;
         data_page_extend_out <= 8'h00;
      end else if (ce_in) begin
         if (pc == `CPURG_TRAP_ADDR && !prog_rd_in)
            fetch_op_out <= `CPURG_TRAP_OP; // RQ14
         else
            fetch_op_out <= prog_byte; // RQ11
         trap_out <= pc == `CPURG_TRAP_ADDR && !prog_rd_in; // RQ14
         instruction_counter_out <= pc_d; // Shows the new counter
         acc_out <= alu_wr_in ? alu_res : acc_q;
         carry_out <= alu_wr_in ? alu_c : carry_q;
         rd_data_out <= mem_rd_in ? rd_val : rd_data_out;
         data_addr_out <= full_addr;
         skip_out <= decrement_skip_zero_in && decrement_skip_zero_new == 8'h00;
         stack_pointer_out <= sp_d;
         primary_ram_pointer_out <= pri_d;
         alt_ram_pointer_out <= alt_d;
         data_page_extend_out <= seg_d;
      end
   end
endmodule

// file: bench/cpurg_core_properties.sv
// Port-level checks for the CPU register and memory map block
`timescale 1ns/100ps
module cpurg_core_chk (
   input logic clk_in,
   input logic resetn_in,
   input logic ce_in,
   input logic [2:0] alu_op_in,
   input logic alu_wr_in,
   input logic alu_imm_in,
   input logic [7:0] imm_in,
   input logic [1:0] src_in,
   input logic [7:0] dir_addr_in,
   input logic mem_rd_in,
   input logic mem_wr_in,
   input logic [1:0] pri_step_in,
   input logic [1:0] alt_step_in,
   input logic push_in,
   input logic pop_in,
   input logic jump_in,
   input logic [14:0] jump_addr_in,
   input logic irq_in,
   input logic ret_in,
   input logic [14:0] prog_addr_out,
   input logic [7:0] fetch_op_out,
   input logic trap_out,
   input logic [14:0] instruction_counter_out,
   input logic [7:0] acc_out,
   input logic carry_out,
   input logic [15:0] data_addr_out,
   input logic [7:0] stack_pointer_out,
   input logic [7:0] primary_ram_pointer_out,
   input logic [7:0] alt_ram_pointer_out,
   input logic [7:0] data_page_extend_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // Return taken while the stack is empty
   sequence s_ret_empty;
      ce_in && ret_in && !irq_in && stack_pointer_out == 8'h6f;
   endsequence
   // Plain jump with no higher-priority counter load
   sequence s_jump;
      ce_in && jump_in && !irq_in && !ret_in;
   endsequence
   AST_RESET_VAL: assert property ($rose(resetn_in) |-> stack_pointer_out == 8'h6f && instruction_counter_out == 15'h0000) else $error("reset values wrong");
   AST_IRQ_VEC: assert property (ce_in && irq_in |=> instruction_counter_out == 15'h00ff) else $error("vector wrong");
   AST_RET_EMPTY: assert property (s_ret_empty |=> instruction_counter_out == 15'h7fff) else $error("empty return wrong");
   AST_JUMP: assert property (s_jump |=> instruction_counter_out == $past(jump_addr_in)) else $error("jump wrong");
   AST_TRAP_FETCH: assert property (ce_in && prog_addr_out == 15'h7fff |=> fetch_op_out == 8'h00 && trap_out) else $error("trap fetch wrong");
   AST_PUSH: assert property (ce_in && push_in && !pop_in && !mem_wr_in |=> stack_pointer_out == $past(stack_pointer_out) - 8'h01) else $error("push wrong");
   AST_PRI_INC: assert property (ce_in && pri_step_in == 2'h1 && !mem_wr_in |=> primary_ram_pointer_out == $past(primary_ram_pointer_out) + 8'h01 && $stable(data_page_extend_out)) else $error("pointer step wrong");
   AST_ALT_DEC: assert property (ce_in && alt_step_in == 2'h2 && !mem_wr_in |=> alt_ram_pointer_out == $past(alt_ram_pointer_out) - 8'h01) else $error("alt step wrong");
   AST_NO_EXT: assert property (ce_in && mem_rd_in && src_in == 2'h0 && dir_addr_in[7] |=> data_addr_out == {8'h00, $past(dir_addr_in)}) else $error("upper address wrong");
   AST_EXT: assert property (ce_in && mem_rd_in && src_in == 2'h0 && !dir_addr_in[7] |=> data_addr_out == {$past(data_page_extend_out), $past(dir_addr_in)}) else $error("segment address wrong");
   AST_STACK_SEG: assert property (ce_in && mem_rd_in && src_in == 2'h3 |=> data_addr_out[15:8] == 8'h00) else $error("stack segment wrong");
   AST_ADD: assert property (ce_in && alu_wr_in && alu_imm_in && alu_op_in == 3'h0 |=> acc_out == 8'($past(acc_out) + $past(imm_in) + {7'h00, $past(carry_out)})) else $error("add wrong");
endmodule

// file: bench/cpurg_core_test.sv
// Self-checking bench for the CPU register and memory map block
`timescale 1ns/100ps
module cpurg_core_test;
   logic clk_in, resetn_in, ce_in, alu_wr_in, alu_imm_in, mem_rd_in;
   logic mem_wr_in, mem_wr_acc_in, push_in, pop_in, jump_in, irq_in;
   logic ret_in, decrement_skip_zero_in, step_in, prog_rd_in, prog_to_ram_in;
   logic prog_erased_in, carry_out, skip_out, trap_out;
   logic [1:0] src_in, pri_step_in, alt_step_in;
   logic [2:0] alu_op_in;
   logic [3:0] decrement_skip_zero_reg_in;
   logic [7:0] imm_in, dir_addr_in, prog_data_in, fetch_op_out, acc_out;
   logic [7:0] rd_data_out, stack_pointer_out, primary_ram_pointer_out;
   logic [7:0] alt_ram_pointer_out, data_page_extend_out, prog_page_out;
   logic [14:0] jump_addr_in, ret_addr_in, prog_rd_addr_in;
   logic [14:0] prog_addr_out, instruction_counter_out;
   logic [15:0] data_addr_out;
   integer errors = 0;
   integer checked = 0;

   cpurg_core u_dut (.*);

   // 10 MHz clock
   always #50 clk_in = ~clk_in;

   // Counts, verdict and end of run
   task give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Compare one value
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked = checked + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Drop every request, keep the block enabled
   task clr;
      {alu_wr_in, alu_imm_in, mem_rd_in, mem_wr_in, mem_wr_acc_in} = '0;
      {push_in, pop_in, jump_in, irq_in, ret_in, decrement_skip_zero_in, step_in} = '0;
      {prog_rd_in, prog_to_ram_in, prog_erased_in, src_in} = '0;
      {pri_step_in, alt_step_in, alu_op_in, decrement_skip_zero_reg_in, imm_in} = '0;
      {dir_addr_in, prog_data_in, jump_addr_in, ret_addr_in} = '0;
      prog_rd_addr_in = '0;
      ce_in = 1'b1;
   endtask

   // One edge, then settle at the falling edge
   task tick;
      @(posedge clk_in);
      @(negedge clk_in);
      clr;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      dir_addr_in = a;
      imm_in = d;
      mem_wr_in = 1'b1;
      tick;
   endtask

   task rd(input logic [7:0] a);
      dir_addr_in = a;
      mem_rd_in = 1'b1;
      tick;
   endtask

   task t_reset;
      chk("sp", 16'h006f, stack_pointer_out);
      chk("counter", 16'h0000, instruction_counter_out);
      $display("t_reset done");
   endtask

   task t_ptr;
      wr(8'hfe, 8'hff);
      pri_step_in = 2'h1;
      tick;
      chk("primary", 16'h0000, primary_ram_pointer_out);
      chk("segment", 16'h0000, data_page_extend_out);
      wr(8'hfc, 8'h00);
      alt_step_in = 2'h2;
      tick;
      chk("alternate", 16'h00ff, alt_ram_pointer_out);
      wr(8'hff, 8'h03);
      chk("segment", 16'h0003, data_page_extend_out);
      rd(8'h10);
      chk("address", 16'h0310, data_addr_out);
      rd(8'h90);
      chk("address", 16'h0090, data_addr_out);
      src_in = 2'h3;
      mem_rd_in = 1'b1;
      tick;
      chk("address", 16'h006f, data_addr_out);
      wr(8'h10, 8'ha5);
      wr(8'hfe, 8'h10);
      src_in = 2'h1;
      mem_rd_in = 1'b1;
      tick;
      chk("read", 16'h00a5, rd_data_out);
      rd(8'hfd);
      chk("read", 16'h006f, rd_data_out);
      wr(8'hff, 8'h00);
      $display("t_ptr done");
   endtask

   task t_counter;
      push_in = 1'b1;
      tick;
      chk("sp", 16'h006e, stack_pointer_out);
      ret_in = 1'b1;
      ret_addr_in = 15'h0123;
      tick;
      chk("counter", 16'h0123, instruction_counter_out);
      pop_in = 1'b1;
      tick;
      chk("sp", 16'h006f, stack_pointer_out);
      ret_in = 1'b1;
      ret_addr_in = 15'h0123;
      tick;
      chk("counter", 16'h7fff, instruction_counter_out);
      prog_data_in = 8'h55;
      tick;
      chk("opcode", 16'h0000, fetch_op_out);
      chk("trap", 16'h0001, trap_out);
      irq_in = 1'b1;
      jump_in = 1'b1;
      jump_addr_in = 15'h4a5b;
      tick;
      chk("counter", 16'h00ff, instruction_counter_out);
      jump_in = 1'b1;
      jump_addr_in = 15'h4a5b;
      tick;
      chk("counter", 16'h4a5b, instruction_counter_out);
      $display("t_counter done");
   endtask

   task t_alu;
      alu_wr_in = 1'b1;
      alu_imm_in = 1'b1;
      alu_op_in = 3'h7;
      imm_in = 8'hf0;
      tick;
      alu_wr_in = 1'b1;
      alu_imm_in = 1'b1;
      imm_in = 8'h20;
      tick;
      chk("acc", 16'h0010, acc_out);
      chk("carry", 16'h0001, carry_out);
      $display("t_alu done");
   endtask

   task t_prog;
      prog_rd_in = 1'b1;
      prog_rd_addr_in = 15'h0123;
      #1;
      chk("prog addr", 16'h0123, prog_addr_out);
      chk("page", 16'h0002, prog_page_out);
      prog_to_ram_in = 1'b1;
      prog_data_in = 8'h3c;
      prog_erased_in = 1'b1;
      wr(8'h20, 8'h00);
      prog_to_ram_in = 1'b1;
      prog_data_in = 8'h3c;
      wr(8'h21, 8'h00);
      rd(8'h20);
      chk("read", 16'h0000, rd_data_out);
      rd(8'h21);
      chk("read", 16'h003c, rd_data_out);
      $display("t_prog done");
   endtask

   task t_decrement_skip_zero;
      jump_in = 1'b1;
      jump_addr_in = 15'h0200;
      tick;
      wr(8'hf0, 8'h01);
      decrement_skip_zero_in = 1'b1;
      step_in = 1'b1;
      tick;
      chk("skip", 16'h0001, skip_out);
      chk("counter", 16'h0202, instruction_counter_out);
      rd(8'hf0);
      chk("read", 16'h0000, rd_data_out);
      $display("t_decrement_skip_zero done");
   endtask

   // Main sequence
   initial begin
      clk_in = 1'b0;
      resetn_in = 1'b0;
      clr;
      repeat (8) @(negedge clk_in);
      resetn_in = 1'b1;
      t_reset;
      t_ptr;
      t_counter;
      t_alu;
      t_prog;
      t_decrement_skip_zero;
      give_verdict;
   end

   // Watchdog against a hang
   initial begin
      #200000;
      errors = errors + 1;
      give_verdict;
   end
endmodule

bind cpurg_core cpurg_core_chk u_chk (.*);
